/* rtl/gspm_top.v */
// Purpose: Pin and mode control of an NDIR carbon dioxide sensor module
// Assumes: Pins arrive asynchronous and pass two flip-flops; pull-ups are
//   external to this logic, so an open strap or calibration pin reads high
// Notes: Message framing of the serial protocols lives outside this block
`timescale 1ns/1ns
`include "gspm_defines.vh"

module gspm_top #(
  parameter [31:0] PWM_PERIOD = `GSPM_PWM_PERIOD_CYC,
  parameter [31:0] TICK_CYC = `GSPM_TICK_CYC,
  parameter [31:0] SERIAL_NUMBER = 32'h0000_0001
) (
  input wire clk,
  input wire rst_b,
  input wire address_strap,
  input wire interface_select_strap,
  input wire cal_pin,
  input wire rx_scl_pin,
  input wire tx_sda_in,
  output reg tx_sda_out,
  output reg tx_sda_oe,
  input wire uart_tx_data,
  input wire i2c_sda_pull_low,
  output reg serial_rx,
  output reg scl_rise,
  output reg scl_fall,
  output reg sda_sampled,
  input wire [15:0] conc_ppm,
  input wire conc_valid,
  output reg alarm_out,
  output reg pwm_out,
  input wire set_valid,
  input wire [1:0] set_sel,
  input wire [23:0] set_data,
  output reg set_ack,
  output reg set_reject,
  input wire mode_valid,
  input wire mode_req,
  output reg power_down,
  input wire sn_req,
  output reg sn_valid,
  output reg [31:0] sn_data,
  input wire proc_start,
  output reg busy_out,
  output reg uart_mode,
  output reg i2c_addr_lsb,
  output reg [23:0] pressure_setting,
  output reg [15:0] altitude_setting,
  output reg [15:0] alarm_trigger,
  output reg [15:0] alarm_release,
  output reg cal_mode,
  output reg air_adjust,
  output reg zero_adjust,
  output reg [15:0] cal_reference
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Bit order: 0 address strap, 1 interface strap, 2 calibration,
  // 3 receive/clock pin, 4 data pin readback
  localparam [2:0] NSYNC = 3'd5;
  wire [4:0] async_in;
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg scl_prev;
  assign async_in = {tx_sda_in, rx_scl_pin, cal_pin, interface_select_strap, address_strap};

  // Two flip-flops per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_a[gi] <= 1'b1;
          sync_b[gi] <= 1'b1;
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Straps and interface mode
  // ----------------------------------------------------------------------
  // Startup counter lets the synchroniser fill before the strap is caught
  reg [1:0] start_cnt;
  reg mode_caught;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_cnt <= 2'd0;
      mode_caught <= 1'b0;
      uart_mode <= 1'b1;
      i2c_addr_lsb <= 1'b1;
    end else begin
      i2c_addr_lsb <= sync_b[0];
      if (!mode_caught) begin
        if (start_cnt == 2'd3) begin
          uart_mode <= sync_b[1];
          mode_caught <= 1'b1;
        end else begin
          start_cnt <= start_cnt + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shared serial pins
  // ----------------------------------------------------------------------
  // UART drives the pin push-pull; I2C only ever pulls it low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sda_out <= 1'b1;
      tx_sda_oe <= 1'b0;
      serial_rx <= 1'b1;
      scl_prev <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      sda_sampled <= 1'b1;
    end else begin
      if (uart_mode) begin
        tx_sda_out <= uart_tx_data;
        tx_sda_oe <= mode_caught;
      end else begin
        tx_sda_out <= 1'b0;
        tx_sda_oe <= i2c_sda_pull_low;
      end
      // Receive/clock pin is only sampled, never driven
      serial_rx <= sync_b[3];
      scl_prev <= sync_b[3];
      scl_rise <= ~uart_mode & sync_b[3] & ~scl_prev;
      scl_fall <= ~uart_mode & ~sync_b[3] & scl_prev;
      sda_sampled <= sync_b[4];
    end
  end

  // ----------------------------------------------------------------------
  // Operating mode and host settings
  // ----------------------------------------------------------------------
  // In I2C mode a write outside power-down is refused with a pulse
  wire set_allowed;
  assign set_allowed = uart_mode | power_down;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_down <= `GSPM_MODE_CONT;
      pressure_setting <= `GSPM_PRESS_RST;
      altitude_setting <= `GSPM_ALT_RST;
      alarm_trigger <= `GSPM_TRIG_RST;
      alarm_release <= `GSPM_REL_RST;
      set_ack <= 1'b0;
      set_reject <= 1'b0;
    end else begin
      set_ack <= 1'b0;
      set_reject <= 1'b0;
      if (mode_valid) begin
        power_down <= mode_req;
      end
      if (set_valid) begin
        if (set_allowed) begin
          set_ack <= 1'b1;
          case (set_sel)
            `GSPM_SEL_PRESS: pressure_setting <= set_data;
            `GSPM_SEL_ALT: altitude_setting <= set_data[15:0];
            `GSPM_SEL_TRIG: alarm_trigger <= set_data[15:0];
            `GSPM_SEL_REL: alarm_release <= set_data[15:0];
            default: set_ack <= 1'b1;
          endcase
        end else begin
          set_reject <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial number readout
  // ----------------------------------------------------------------------
  // SERIAL_NUMBER default is arbitrary; each unit overrides it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sn_valid <= 1'b0;
      sn_data <= 32'h0000_0000;
    end else begin
      sn_valid <= sn_req;
      if (sn_req) begin
        sn_data <= SERIAL_NUMBER;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alarm with hysteresis
  // ----------------------------------------------------------------------
  reg [15:0] conc_hold;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conc_hold <= 16'h0000;
      alarm_out <= 1'b0;
    end else begin
      if (conc_valid) begin
        conc_hold <= conc_ppm;
      end
      if (conc_hold > alarm_trigger) begin
        alarm_out <= 1'b1;
      end else if (conc_hold < alarm_release) begin
        alarm_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Concentration pulse output
  // ----------------------------------------------------------------------
  // High time is taken once per period so the width never tears mid-pulse
  reg [31:0] pwm_cnt;
  reg [31:0] pwm_high;
  wire [31:0] conc_sat;
  wire [47:0] scaled;
  wire [31:0] next_high;
  assign conc_sat = (conc_hold >= `GSPM_CONC_FULL16) ? `GSPM_CONC_FULL :
                    {16'h0000, conc_hold};
  assign scaled = conc_sat * {16'h0000, PWM_PERIOD};
  assign next_high = scaled[31:0] / `GSPM_CONC_FULL;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt <= 32'h0000_0000;
      pwm_high <= 32'h0000_0000;
      pwm_out <= 1'b0;
    end else begin
      if (pwm_cnt >= PWM_PERIOD - 32'd1) begin
        pwm_cnt <= 32'h0000_0000;
        pwm_high <= next_high;
      end else begin
        pwm_cnt <= pwm_cnt + 32'd1;
      end
      pwm_out <= (pwm_cnt < pwm_high);
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------------
  reg [31:0] tick_cnt;
  reg ms_tick;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (tick_cnt >= TICK_CYC - 32'd1) begin
        tick_cnt <= 32'h0000_0000;
        ms_tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Calibration pin timing
  // ----------------------------------------------------------------------
  // Zero adjust fires once twelve seconds are reached; release then ends it
  localparam [1:0] CAL_IDLE = 2'd0;
  localparam [1:0] CAL_LOW = 2'd1;
  localparam [1:0] CAL_DONE = 2'd2;
  reg [1:0] cal_state;
  reg [15:0] low_ms;
  wire cal_low;
  assign cal_low = ~sync_b[2];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_state <= CAL_IDLE;
      low_ms <= 16'h0000;
      cal_mode <= 1'b0;
      air_adjust <= 1'b0;
      zero_adjust <= 1'b0;
      cal_reference <= `GSPM_AIR_REF;
    end else begin
      air_adjust <= 1'b0;
      zero_adjust <= 1'b0;
      case (cal_state)
        CAL_IDLE: begin
          low_ms <= 16'h0000;
          if (cal_low) begin
            cal_state <= CAL_LOW;
            cal_mode <= 1'b1;
          end
        end
        CAL_LOW: begin
          if (!cal_low) begin
            cal_state <= CAL_IDLE;
            cal_mode <= 1'b0;
            if (low_ms >= `GSPM_AIR_MIN_MS && low_ms <= `GSPM_AIR_MAX_MS) begin
              air_adjust <= 1'b1;
              cal_reference <= `GSPM_AIR_REF;
            end
          end else if (low_ms >= `GSPM_ZERO_MIN_MS) begin
            zero_adjust <= 1'b1;
            cal_reference <= `GSPM_ZERO_REF;
            cal_state <= CAL_DONE;
          end else if (ms_tick) begin
            low_ms <= low_ms + 16'd1;
          end
        end
        CAL_DONE: begin
          if (!cal_low) begin
            cal_state <= CAL_IDLE;
            cal_mode <= 1'b0;
          end
        end
        default: begin
          cal_state <= CAL_IDLE;
          cal_mode <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Busy indication
  // ----------------------------------------------------------------------
  // A new processing request or an adjustment restarts the busy window
  reg [15:0] busy_ms;
  wire busy_start;
  assign busy_start = proc_start | air_adjust | zero_adjust;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ms <= 16'h0000;
      busy_out <= 1'b0;
    end else begin
      if (busy_start) begin
        busy_ms <= `GSPM_BUSY_MS;
        busy_out <= 1'b1;
      end else if (busy_ms == 16'h0000) begin
        busy_out <= 1'b0;
      end else if (ms_tick) begin
        busy_ms <= busy_ms - 16'd1;
      end
    end
  end

endmodule

/* rtl/gspm_defines.vh */
// Purpose: Shared constants for the gas sensor pin and mode control block
// Assumes: 125 MHz system clock, concentrations in ppm, times in milliseconds
// Notes: Cycle counts are derived from the clock rate and the nominal times
`ifndef GSPM_DEFINES_VH
`define GSPM_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define GSPM_CLK_HZ 125000000
`define GSPM_PWM_HZ 1000
`define GSPM_PWM_PERIOD_CYC (`GSPM_CLK_HZ / `GSPM_PWM_HZ)
`define GSPM_MS_PER_S 1000
`define GSPM_TICK_CYC (`GSPM_CLK_HZ / `GSPM_MS_PER_S)
`define GSPM_AIR_MIN_MS 16'd4000
`define GSPM_AIR_MAX_MS 16'd10000
`define GSPM_ZERO_MIN_MS 16'd12000
`define GSPM_BUSY_MS 16'd500

// ----------------------------------------------------------------------
// Concentration scale and reset values
// ----------------------------------------------------------------------
`define GSPM_CONC_FULL 32'd5000
`define GSPM_CONC_FULL16 16'd5000
`define GSPM_TRIG_RST 16'd1000
`define GSPM_REL_RST 16'd900
`define GSPM_PRESS_RST 24'd101325
`define GSPM_ALT_RST 16'd0
`define GSPM_AIR_REF 16'd400
`define GSPM_ZERO_REF 16'd0

// ----------------------------------------------------------------------
// Setting selectors and operating modes
// ----------------------------------------------------------------------
`define GSPM_SEL_PRESS 2'h0
`define GSPM_SEL_ALT 2'h1
`define GSPM_SEL_TRIG 2'h2
`define GSPM_SEL_REL 2'h3
`define GSPM_MODE_CONT 1'b0
`define GSPM_MODE_PDOWN 1'b1

`endif

/* tb/gspm_top_props.sv */
// Purpose: Concurrent checks on the pin and mode control ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Attached to the top module by the bind at the foot
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module gspm_top_props #(
  parameter [31:0] SERIAL_NUMBER = 32'h0000_0001
) (
  input wire clk, rst_b, set_valid, uart_mode, power_down, set_ack, set_reject,
  input wire conc_valid, alarm_out, sn_req, sn_valid, proc_start, busy_out,
  input wire scl_rise, scl_fall, tx_sda_oe, tx_sda_out, i2c_sda_pull_low,
  input wire uart_tx_data, air_adjust, zero_adjust,
  input wire [15:0] conc_ppm, alarm_trigger, alarm_release, cal_reference,
  input wire [31:0] sn_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Setting writes and their answers
  set_accept_a: assert property (
    set_valid && (uart_mode || power_down) |=> set_ack && !set_reject)
    else $error("setting write not acknowledged");
  set_refuse_a: assert property (
    set_valid && !uart_mode && !power_down |=> set_reject && !set_ack && $stable(alarm_trigger))
    else $error("setting write not refused");
  // Alarm hysteresis two cycles after a new reading
  alarm_set_a: assert property (
    conc_valid && !set_valid && conc_ppm > alarm_trigger |-> ##2 alarm_out)
    else $error("alarm not raised");
  alarm_clear_a: assert property (
    conc_valid && !set_valid && conc_ppm < alarm_release |-> ##2 !alarm_out)
    else $error("alarm not cleared");
  // Serial number answer and busy flag
  sn_answer_a: assert property (sn_req |=> sn_valid && sn_data == SERIAL_NUMBER)
    else $error("serial number answer wrong");
  busy_start_a: assert property (proc_start || air_adjust || zero_adjust |=> busy_out)
    else $error("busy not raised");
  busy_hold_a: assert property ($rose(busy_out) |-> busy_out [*8])
    else $error("busy dropped early");
  // Shared pin roles by interface mode
  scl_quiet_a: assert property (uart_mode |-> !scl_rise && !scl_fall)
    else $error("clock edges reported in UART mode");
  sda_follow_a: assert property (
    !uart_mode && $past(!uart_mode) |-> tx_sda_oe == $past(i2c_sda_pull_low) && !tx_sda_out)
    else $error("data line drive wrong");
  tx_follow_a: assert property (
    uart_mode && $past(uart_mode) && $past(tx_sda_oe) |-> tx_sda_oe && tx_sda_out == $past(uart_tx_data))
    else $error("transmit line wrong");
  // Adjustment references
  air_ref_a: assert property (air_adjust |=> cal_reference == 16'h0190)
    else $error("air reference wrong");
  zero_ref_a: assert property (zero_adjust |=> cal_reference == 16'h0000)
    else $error("zero reference wrong");
endmodule

bind gspm_top gspm_top_props #(.SERIAL_NUMBER(SERIAL_NUMBER)) i_props (.*);

/* tb/gspm_host_model.sv */
// Purpose: Host controller at the far side of the shared serial pins
// Assumes: Data wire is open-drain with a pull-up; clock idles high
// Notes: Clock runs only while run is set and the block is not busy
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host model
// ----------------------------------------------------------------
module gspm_host_model (
  input wire run, busy_out, tx_sda_out, tx_sda_oe,
  output reg rx_scl_pin,
  output wire tx_sda_in
);
  // Released wire shows the pull-up level
  assign tx_sda_in = tx_sda_oe ? tx_sda_out : 1'b1;
  // Serial clock of 125 ns, held high between frames and while busy
  initial begin
    rx_scl_pin = 1'b1;
    forever begin
      #62 rx_scl_pin = (run && !busy_out) ? ~rx_scl_pin : 1'b1;
      #63 rx_scl_pin = (run && !busy_out) ? ~rx_scl_pin : 1'b1;
    end
  end
endmodule

/* tb/gspm_top_bench.sv */
// Purpose: Self-checking bench of the pin and mode control block
// Assumes: Open straps and calibration pin are modelled as driven high
// Notes: Short PWM period and millisecond tick keep the run brief
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module gspm_top_bench;
  localparam [31:0] PP = 32'd100;
  localparam [31:0] TK = 32'd2;
  localparam [31:0] SN = 32'h5A5A_0C3E; // Arbitrary serial number
  reg clk, rst_b, address_strap, interface_select_strap, cal_pin, uart_tx_data;
  reg i2c_sda_pull_low, conc_valid, set_valid, mode_valid, mode_req, sn_req, proc_start, run;
  reg [15:0] conc_ppm;
  reg [1:0] set_sel;
  reg [23:0] set_data;
  wire rx_scl_pin, tx_sda_in, tx_sda_out, tx_sda_oe, serial_rx, scl_rise, scl_fall;
  wire sda_sampled, alarm_out, pwm_out, set_ack, set_reject, power_down, sn_valid, busy_out;
  wire uart_mode, i2c_addr_lsb, cal_mode, air_adjust, zero_adjust;
  wire [31:0] sn_data;
  wire [23:0] pressure_setting;
  wire [15:0] altitude_setting, alarm_trigger, alarm_release, cal_reference;
  integer fails = 0;
  integer tests_run = 0;
  integer n, m, i, h;

  gspm_top #(.PWM_PERIOD(PP), .TICK_CYC(TK), .SERIAL_NUMBER(SN)) i_dut (.*);
  gspm_host_model i_host (.*);

  // Clock and time-zero input values
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_b, address_strap, interface_select_strap, cal_pin, uart_tx_data} = 5'h0F;
    {i2c_sda_pull_low, conc_valid, set_valid, mode_valid, mode_req} = 5'h00;
    {sn_req, proc_start, run, conc_ppm, set_sel, set_data} = 45'h0;
  end

  // Compare and verdict
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %0s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task conclude;
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task ng(input integer k);
    repeat (k) @(negedge clk);
  endtask

  // Reset with given straps, then reset values
  task rst(input ms, input ad);
    @(posedge clk);
    rst_b <= 1'b0;
    interface_select_strap <= ms;
    address_strap <= ad;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    ng(6);
    chk("mode", uart_mode, ms);
    chk("addr", i2c_addr_lsb, ad);
    chk("press", pressure_setting, 24'h018BCD);
    chk("alt", altitude_setting, 16'h0000);
    chk("trig", alarm_trigger, 16'h03E8);
    chk("rel", alarm_release, 16'h0384);
  endtask

  // Setting write with expected answer
  task wr(input [1:0] s, input [23:0] d, input ok);
    @(posedge clk);
    set_valid <= 1'b1;
    set_sel <= s;
    set_data <= d;
    @(posedge clk);
    set_valid <= 1'b0;
    ng(1);
    chk("ack", set_ack, ok);
    chk("rej", set_reject, !ok);
  endtask

  // Mode change
  task mode(input md);
    @(posedge clk);
    mode_valid <= 1'b1;
    mode_req <= md;
    @(posedge clk);
    mode_valid <= 1'b0;
    ng(2);
    chk("pdown", power_down, md);
  endtask

  // New concentration reading
  task conc(input [15:0] v);
    @(posedge clk);
    conc_ppm <= v;
    conc_valid <= 1'b1;
    @(posedge clk);
    conc_valid <= 1'b0;
  endtask

  // Alarm level two cycles after a reading
  task al(input [15:0] v, input e);
    conc(v);
    ng(2);
    chk("alarm", alarm_out, e);
  endtask

  // Serial number request
  task t_sn;
    @(posedge clk);
    sn_req <= 1'b1;
    @(posedge clk);
    sn_req <= 1'b0;
    ng(1);
    chk("snv", sn_valid, 1'b1);
    ng(1);
    chk("snv", sn_valid, 1'b0);
    chk("snd", sn_data, SN);
  endtask

  // High time and rising edges of the PWM over three periods
  task pw(input [15:0] v);
    h = (v > 16'h1388 ? 5000 : v) * PP / 5000;
    conc(v);
    ng(3 * PP);
    n = 0;
    m = 0;
    i = pwm_out;
    repeat (3 * PP) begin
      @(negedge clk);
      if (pwm_out === 1'b1) begin
        n = n + 1;
        if (i == 0) m = m + 1;
      end
      i = pwm_out;
    end
    chk("high", n, 3 * h);
    chk("rise", m, (h > 0 && h < PP) ? 3 : 0);
  endtask

  // Busy length after a processing start
  task t_busy;
    @(posedge clk);
    proc_start <= 1'b1;
    @(posedge clk);
    proc_start <= 1'b0;
    ng(1);
    chk("busy", busy_out, 1'b1);
    n = 0;
    while (busy_out === 1'b1 && n < 1200) begin
      @(negedge clk);
      n = n + 1;
    end
    chk("busylen", n >= 498 * TK && n <= 502 * TK, 1'b1);
  endtask

  // Shared pins: drive low, count clock edges, release
  task t_pins(input integer lo, input integer hi);
    @(posedge clk);
    uart_tx_data <= 1'b0;
    i2c_sda_pull_low <= 1'b1;
    run <= 1'b1;
    ng(2);
    chk("oe", tx_sda_oe, 1'b1);
    chk("out", tx_sda_out, 1'b0);
    ng(3);
    chk("sda", sda_sampled, 1'b0);
    n = 0;
    m = 0;
    h = 0;
    i = serial_rx;
    repeat (625) begin
      @(negedge clk);
      if (scl_rise === 1'b1) n = n + 1;
      if (scl_fall === 1'b1) h = h + 1;
      if (serial_rx === 1'b1 && i == 0) m = m + 1;
      i = serial_rx;
    end
    chk("scl", n >= lo && n <= hi, 1'b1);
    chk("sclfall", h >= lo && h <= hi, 1'b1);
    chk("rx", m >= 39 && m <= 41, 1'b1);
    @(posedge clk);
    uart_tx_data <= 1'b1;
    i2c_sda_pull_low <= 1'b0;
    run <= 1'b0;
    ng(5);
    chk("sdaidle", sda_sampled, 1'b1);
  endtask

  // Calibration pin held low for a number of milliseconds
  task cnt(input integer k);
    repeat (k) begin
      @(negedge clk);
      n = n + air_adjust;
      m = m + zero_adjust;
    end
  endtask
  task t_cal(input integer ms, input ea, input ez);
    @(posedge clk);
    cal_pin <= 1'b0;
    n = 0;
    m = 0;
    cnt(ms * TK);
    chk("calmode", cal_mode, 1'b1);
    @(posedge clk);
    cal_pin <= 1'b1;
    cnt(10);
    chk("calend", cal_mode, 1'b0);
    chk("air", n, ea);
    chk("zero", m, ez);
    if (ea || ez) begin
      chk("calref", cal_reference, ez ? 16'h0000 : 16'h0190);
      ng(1100);
    end
  endtask

  // Main sequence
  initial begin
    rst(1'b1, 1'b1);
    t_sn;
    wr(2'h0, 24'h015F90, 1'b1);
    chk("press", pressure_setting, 24'h015F90);
    wr(2'h1, 24'h0001F4, 1'b1);
    chk("alt", altitude_setting, 16'h01F4);
    wr(2'h2, 24'h0004B0, 1'b1);
    chk("trig", alarm_trigger, 16'h04B0);
    wr(2'h3, 24'h000320, 1'b1);
    chk("rel", alarm_release, 16'h0320);
    al(16'h044C, 1'b0);
    al(16'h04B1, 1'b1);
    al(16'h04B0, 1'b1);
    al(16'h0320, 1'b1);
    al(16'h031F, 1'b0);
    al(16'h044C, 1'b0);
    pw(16'h04E2);
    pw(16'h0000);
    pw(16'h1770);
    t_busy;
    t_pins(0, 0);
    t_cal(3900, 1'b0, 1'b0);
    t_cal(12100, 1'b0, 1'b1);
    t_cal(4100, 1'b1, 1'b0);
    t_cal(10500, 1'b0, 1'b0);
    rst(1'b0, 1'b0);
    wr(2'h2, 24'h0007D0, 1'b0);
    chk("trig", alarm_trigger, 16'h03E8);
    mode(1'b1);
    wr(2'h2, 24'h0007D0, 1'b1);
    chk("trig", alarm_trigger, 16'h07D0);
    mode(1'b0);
    t_pins(39, 41);
    conclude;
  end

  // Watchdog against a hung run
  initial begin
    #720000;
    fails = fails + 1;
    conclude;
  end
endmodule
